// ### bench/clock_output_select_assertions.sv
`timescale 1ns/1ns
// ==========
// Checker on the top module's ports
module clock_output_select_assertions
	import clock_output_select_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys, nrst,
	// Inputs, plus the control register readback
	input wire logic mainClockIn, singleEndedClockIn, singleEndedRefSelect,
	input wire logic synthEnablePin, powerDownPin, referenceRepeatEnable,
	input wire logic timeMarkIn, triggerCtrlWrite, pinOverrideEnable,
	input wire logic [TRIG_CTRL_W-1:0] triggerCtrlData, triggerCtrlRead,
	input wire logic [1:0] clockConfigPins,
	input wire logic overrangeEnable,
	input wire logic [AUX_COUNT-1:0] overRangeIn,
	// Outputs
	input wire logic referenceRepeatOut, triggerClockOut, auxOutC, auxOutD,
	input wire logic [4:0] auxCFunction, auxDFunction
);
	logic selRef, stamp;
	assign selRef = singleEndedRefSelect ? singleEndedClockIn : mainClockIn;
	assign stamp = triggerCtrlRead[TRIG_EN_BIT] &&
		triggerCtrlRead[TRIG_MODE_LSB+:TRIG_MODE_W] == TRIG_MODE_TIMESTAMP;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	AST_REPEAT: assert property ($past(nrst) |->
		referenceRepeatOut == $past(selRef && synthEnablePin &&
		referenceRepeatEnable && !powerDownPin)) else $error("repeat wrong");
	AST_PD_REPEAT: assert property (powerDownPin |=>
		!referenceRepeatOut) else $error("repeat on in power-down");
	AST_PD_AUX: assert property (powerDownPin |=>
		!auxOutC && !auxOutD) else $error("aux on in power-down");
	AST_TRIG_OFF: assert property (
		!triggerCtrlRead[TRIG_EN_BIT] |=>
		!triggerClockOut) else $error("trigger on while disabled");
	AST_CTRL: assert property (triggerCtrlWrite |=>
		triggerCtrlRead == $past(triggerCtrlData)) else $error("ctrl lost");
	AST_MARK: assert property (stamp && $past(stamp) |->
		triggerClockOut == $past(timeMarkIn, 2)) else $error("mark wrong");
	AST_OVR: assert property ($past(auxCFunction == FN_OVR) &&
		$past(nrst) |-> auxOutC == $past(overRangeIn[AUX_C] && !powerDownPin))
		else $error("over-range output wrong");
	AST_STRAP_OVR: assert property (!pinOverrideEnable &&
		clockConfigPins == AUX_CODE_OFF && overrangeEnable && !powerDownPin
		&& auxCFunction inside {FN_OFF, FN_OVR} |=> auxCFunction == FN_OVR)
		else $error("strap over-range not taken");
	AST_D_NEEDS_C: assert property (auxDFunction inside
		{FN_REF, FN_DIV2, FN_DIV4} |-> !(auxCFunction inside {FN_OFF, FN_OVR}))
		else $error("aux D clock without aux C clock");
	cover property (stamp ##1 stamp);
	cover property (auxCFunction == FN_DIV4);
	cover property (auxDFunction == FN_DIV2);
endmodule
bind clock_output_select clock_output_select_assertions u_chk (.*);

// ### bench/clock_output_select_bench.sv
`timescale 1ns/1ns
module clock_output_select_bench;
	import clock_output_select_pkg::*;
	logic clk_sys = 1'b0, nrst = 1'b0, clr = 1'b1, wr = 1'b0, mark = 1'b0;
	logic sel = 1'b0, synth = 1'b0, pd = 1'b0, repEn = 1'b1;
	logic ovr = 1'b0, ovrEn = 1'b0;
	logic [TRIG_CTRL_W-1:0] wdat = 7'h00, rd;
	logic [1:0] pins = 2'h0, cMode = 2'h0, dMode = 2'h0, orIn = 2'h0;
	logic [15:0] cyc = 16'h0000;
	logic [2:0] hist = 3'h0;
	logic outRep, outTrig, outC, outD;
	logic [4:0] fnC, fnD;
	logic [3:0][7:0] edges;
	int mismatches = 0, cmp_count = 0, d;
	// ==========
	// Clocks: references and serializer come from one cycle counter
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		cyc <= cyc + 16'h0001;
		if (cyc == 16'h4e20) begin
			mismatches++;
			test_done();
		end
	end
	clock_output_select i_dut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1),
		.mainClockIn(cyc[2]), .singleEndedClockIn(cyc[1]),
		.singleEndedRefSelect(sel), .synthEnablePin(synth),
		.powerDownPin(pd), .referenceRepeatEnable(repEn),
		.serializerClockIn(cyc[0]), .timeMarkIn(mark),
		.triggerCtrlWrite(wr), .triggerCtrlData(wdat),
		.clockConfigPins(pins), .pinOverrideEnable(ovr),
		.auxCDividerMode(cMode), .auxDDividerMode(dMode),
		.overrangeEnable(ovrEn), .overRangeIn(orIn),
		.referenceRepeatOut(outRep), .triggerClockOut(outTrig),
		.auxOutC(outC), .auxOutD(outD), .triggerCtrlRead(rd),
		.auxCFunction(fnC), .auxDFunction(fnD));
	clock_sink_model i_sink (.clk_sys(clk_sys), .clr(clr),
		.clkIn({outRep, outD, outC, outTrig}), .edges(edges));
	// ==========
	// Expectations and compares
	function automatic logic [7:0] edgesOf(input logic [1:0] code);
		// Main reference period is 8 cycles, window 128
		return code == AUX_CODE_OFF ? 8'h00 : 8'(128 >> (int'(code) + 2));
	endfunction
	function automatic logic [4:0] fnOf(input logic [1:0] code);
		case (code)
			AUX_CODE_OFF: return pd ? FN_OFF : ovrEn ? FN_OVR : FN_OFF;
			AUX_CODE_REF: return pd ? FN_OFF : FN_REF;
			AUX_CODE_DIV2: return pd ? FN_OFF : FN_DIV2;
			default: return pd ? FN_OFF : FN_DIV4;
		endcase
	endfunction
	task automatic check(input string what, input logic [7:0] e, got);
		cmp_count++;
		if (got !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, e, got);
		end
	endtask
	// Sampled clocks drift a cycle against the window, allow one edge
	task automatic checkCnt(input string what, input logic [7:0] e, got);
		cmp_count++;
		if (!(got === e || got === e + 8'h01 || got + 8'h01 === e)) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, e, got);
		end
	endtask
	task automatic measure(input int settle, input int n);
		repeat (settle) @(negedge clk_sys);
		clr = 1'b1;
		@(negedge clk_sys);
		clr = 1'b0;
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wrCtrl(input logic [TRIG_CTRL_W-1:0] v);
		wdat = v;
		wr = 1'b1;
		@(negedge clk_sys);
		wr = 1'b0;
	endtask
	task automatic auxCheck(input logic [1:0] cc, dc);
		measure(40, 128);
		check("fnC", {3'h0, fnOf(cc)}, {3'h0, fnC});
		check("fnD", {3'h0, fnOf(dc)}, {3'h0, fnD});
		checkCnt("auxC", pd ? 8'h00 : edgesOf(cc), edges[1]);
		checkCnt("auxD", pd ? 8'h00 : edgesOf(dc), edges[2]);
	endtask
	task automatic test_done();
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========
	// Main sequence
	initial begin
		void'($urandom(26481));
		repeat (16) @(negedge clk_sys);
		nrst = 1'b1;
		measure(0, 64);
		check("ctrl", 8'h00, {1'b0, rd});
		checkCnt("trig", 8'h00, edges[0]);
		for (int i = 0; i < 16; i++) begin
			{sel, synth, repEn, pd} = 4'(i);
			measure(4, 64);
			checkCnt("repeat", synth && repEn && !pd ?
				(sel ? 8'h10 : 8'h08) : 8'h00, edges[3]);
		end
		// Divider 1 avoided: a sampled serializer cannot be passed at full rate
		for (int i = 0; i < 8; i++) begin
			d = i == 0 ? 0 : i == 1 ? 15 : 2 + $urandom % 14;
			wrCtrl({4'(d), 2'($urandom % 3), 1'b1});
			measure(8, 128);
			check("ctrl", {1'b0, wdat}, {1'b0, rd});
			checkCnt("trig", d ? 8'(64 / d) : 8'h00, edges[0]);
		end
		wrCtrl({4'h0, TRIG_MODE_TIMESTAMP, 1'b1});
		repeat (4) @(negedge clk_sys);
		for (int i = 0; i < 64; i++) begin
			@(negedge clk_sys);
			check("mark", {7'h00, hist[1]}, {7'h00, outTrig});
			mark = 1'($urandom);
			hist = {hist[1:0], mark};
		end
		// Aux windows assume the main reference, period 8 cycles
		sel = 1'b0;
		for (int i = 0; i < 8; i++) begin
			{pd, pins} = 3'(i);
			{ovrEn, cMode, dMode} = 5'($urandom);
			auxCheck(pins, pins != 2'h0 ? AUX_CODE_REF : AUX_CODE_OFF);
		end
		ovr = 1'b1;
		pd = 1'b0;
		for (int i = 0; i < 16; i++) begin
			{cMode, dMode} = 4'(i);
			{ovrEn, pins} = 3'($urandom);
			auxCheck(cMode, cMode != 2'h0 ? dMode : 2'h0);
		end
		cMode = AUX_CODE_OFF;
		ovrEn = 1'b1;
		repeat (32) begin
			@(negedge clk_sys);
			orIn = 2'($urandom);
		end
		cMode = AUX_CODE_REF;
		dMode = AUX_CODE_OFF;
		orIn = 2'h3;
		auxCheck(AUX_CODE_REF, AUX_CODE_OFF);
		test_done();
	end
endmodule

// ### bench/clock_sink_model.sv
`timescale 1ns/1ns
// ==========
// Receiving end: counts rising edges of each clock
module clock_sink_model (
	// Clock and control
	input wire logic clk_sys,
	input wire logic clr,
	// Received clocks
	input wire logic [3:0] clkIn,
	// Edge counts, wrap at 255 so windows stay short
	output logic [3:0][7:0] edges
);
	logic [3:0] prev_r;
	always_ff @(posedge clk_sys) begin
		prev_r <= clkIn;
		for (int i = 0; i < 4; i++) begin
			if (clr)
				edges[i] <= 8'h00;
			else if (clkIn[i] && !prev_r[i])
				edges[i] <= edges[i] + 8'h01;
		end
	end
endmodule

// ### hw/clock_output_select.sv
`timescale 1ns/1ns
module clock_output_select
	import clock_output_select_pkg::*;
#(
	parameter bit QUAD_PART = 1'b1,
	parameter int DIV_W = TRIG_DIV_W
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clkEn,
	// Reference inputs and straps
	input wire logic mainClockIn,
	input wire logic singleEndedClockIn,
	input wire logic singleEndedRefSelect,
	input wire logic synthEnablePin,
	input wire logic powerDownPin,
	input wire logic referenceRepeatEnable,
	// Trigger path
	input wire logic serializerClockIn,
	input wire logic timeMarkIn,
	input wire logic triggerCtrlWrite,
	input wire logic [TRIG_CTRL_W-1:0] triggerCtrlData,
	// Aux configuration
	input wire logic [1:0] clockConfigPins,
	input wire logic pinOverrideEnable,
	input wire logic [1:0] auxCDividerMode,
	input wire logic [1:0] auxDDividerMode,
	input wire logic overrangeEnable,
	input wire logic [AUX_COUNT-1:0] overRangeIn,
	// Clock outputs
	output logic referenceRepeatOut,
	output logic triggerClockOut,
	output logic auxOutC,
	output logic auxOutD,
	// Status
	output logic [TRIG_CTRL_W-1:0] triggerCtrlRead,
	output logic [4:0] auxCFunction,
	output logic [4:0] auxDFunction
);

	// =====================================================
	// Reference sampling
	logic selRef;
	logic refLevel_r;
	logic refPrev_r;
	logic refRise;
	logic refFall;
	logic [REF_DIV_BITS-1:0] refDiv;
	logic refWrapNext;

	// Reference taken straight from the chosen input
	assign selRef = singleEndedRefSelect ? singleEndedClockIn
		: mainClockIn; // see [R1]

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			refLevel_r <= 1'b0;
			refPrev_r <= 1'b0;
		end else if (clkEn) begin
			refLevel_r <= selRef;
			refPrev_r <= refLevel_r;
		end
	end

	assign refRise = refLevel_r & ~refPrev_r;
	assign refFall = ~refLevel_r & refPrev_r;

	ref_divider #(
		.DIV_BITS(REF_DIV_BITS)
	) u_refDiv (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clkEn(clkEn),
		.refRise(refRise),
		.run(~powerDownPin),
		.divOut(refDiv),
		.wrapNext(refWrapNext)
	);

	// =====================================================
	// Reference repeat output
	logic repeatOn;
	logic referenceRepeatOut_r;

	// Enable input defaults high in the device, so PLL on means repeat on
	assign repeatOn = synthEnablePin // see [R2] [R3]
		& referenceRepeatEnable // see [R2]
		& ~powerDownPin; // see [R3] [R4]

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			referenceRepeatOut_r <= 1'b0;
		end else if (clkEn) begin
			referenceRepeatOut_r <= repeatOn & selRef; // see [R1]
		end
	end

	assign referenceRepeatOut = referenceRepeatOut_r;

	// =====================================================
	// Trigger output control register
	logic [TRIG_CTRL_W-1:0] triggerCtrl_r;
	logic trigEnable;
	logic [TRIG_MODE_W-1:0] trigMode;
	logic [DIV_W-1:0] trigDiv;

	// Cleared at reset: host must write enable before anything leaves
	always_ff @(posedge clk_sys or negedge nrst) begin // see [R6]
		if (!nrst) begin
			triggerCtrl_r <= TRIG_CTRL_RESET;
		end else if (clkEn && triggerCtrlWrite) begin
			triggerCtrl_r <= triggerCtrlData; // see [R7]
		end
	end

	assign trigEnable = triggerCtrl_r[TRIG_EN_BIT]; // see [R7]
	assign trigMode = triggerCtrl_r[TRIG_MODE_LSB +: TRIG_MODE_W];
	assign trigDiv = triggerCtrl_r[TRIG_DIV_LSB +: DIV_W];
	assign triggerCtrlRead = triggerCtrl_r;

	// =====================================================
	// Serializer clock divider
	logic serLevel_r;
	logic serPrev_r;
	logic serRise;
	logic [DIV_W-1:0] serCount_r;
	logic [DIV_W-1:0] serHigh;
	logic serDivOut_r;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			serLevel_r <= 1'b0;
			serPrev_r <= 1'b0;
		end else if (clkEn) begin
			serLevel_r <= serializerClockIn;
			serPrev_r <= serLevel_r;
		end
	end

	assign serRise = serLevel_r & ~serPrev_r;
	// High for the first half, rounded up, of each divided period
	// One spare bit so the largest divider does not wrap to zero
	assign serHigh = DIV_W'(({1'b0, trigDiv} + 1'b1) >> 1);

	// One output period per divider-value serializer edges
	always_ff @(posedge clk_sys or negedge nrst) begin // see [R8]
		if (!nrst) begin
			serCount_r <= '0;
		end else if (clkEn) begin
			if (!trigEnable || trigDiv == '0) begin
				serCount_r <= '0;
			end else if (serRise) begin
				if (serCount_r >= trigDiv - 1'b1) begin
					serCount_r <= '0;
				end else begin
					serCount_r <= serCount_r + 1'b1;
				end
			end
		end
	end

	// A zero divider holds the output low rather than guessing a ratio
	always_ff @(posedge clk_sys or negedge nrst) begin // see [R8]
		if (!nrst) begin
			serDivOut_r <= 1'b0;
		end else if (clkEn) begin
			serDivOut_r <= (trigDiv != '0) && (serCount_r < serHigh);
		end
	end

	// =====================================================
	// Time mark retiming and trigger output mux
	logic timeMark_r;
	logic triggerClockOut_r;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			timeMark_r <= 1'b0;
		end else if (clkEn) begin
			timeMark_r <= timeMarkIn;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			triggerClockOut_r <= 1'b0;
		end else if (clkEn) begin
			if (!trigEnable) begin
				triggerClockOut_r <= 1'b0; // see [R6]
			end else if (trigMode == TRIG_MODE_TIMESTAMP) begin
				triggerClockOut_r <= timeMark_r; // see [R5] [R19]
			end else begin
				triggerClockOut_r <= serDivOut_r; // see [R5] [R8]
			end
		end
	end

	assign triggerClockOut = triggerClockOut_r;

	// =====================================================
	// Aux function decode
	function automatic aux_fn_t pickFn(input logic [1:0] code,
		input logic ovrAllowed);
		aux_fn_t fn;
		case (code)
			AUX_CODE_REF: fn = FN_REF;
			AUX_CODE_DIV2: fn = FN_DIV2;
			AUX_CODE_DIV4: fn = FN_DIV4;
			// Over-range only where no clock function is chosen
			AUX_CODE_OFF: fn = ovrAllowed ? FN_OVR : FN_OFF; // see [R13]
			default: fn = FN_OFF;
		endcase
		return fn;
	endfunction

	logic [1:0] auxCode [AUX_COUNT];
	logic ovrAllowed;
	logic auxCClockOn;

	assign ovrAllowed = overrangeEnable & QUAD_PART;
	assign auxCClockOn = (auxCDividerMode != AUX_CODE_OFF);

	always_comb begin
		auxCode[AUX_C] = AUX_CODE_OFF;
		auxCode[AUX_D] = AUX_CODE_OFF;
		if (pinOverrideEnable) begin // see [R11]
			auxCode[AUX_C] = auxCDividerMode; // see [R16]
			// Aux D clock rides on aux C clock being enabled
			auxCode[AUX_D] = auxCClockOn ? auxDDividerMode
				: AUX_CODE_OFF; // see [R14] [R18]
		end else begin
			auxCode[AUX_C] = clockConfigPins; // see [R12] [R15]
			// Straps give aux D on or off, never a ratio
			auxCode[AUX_D] = (clockConfigPins != AUX_CODE_OFF)
				? AUX_CODE_REF : AUX_CODE_OFF; // see [R12] [R17]
		end
	end

	// =====================================================
	// Per-output selection and drive
	aux_fn_t curFn_r [AUX_COUNT];
	logic [AUX_COUNT-1:0] auxOut_r;

	genvar g;
	generate
		for (g = 0; g < AUX_COUNT; g++) begin : gAux
			aux_fn_t wantFn;
			logic curIsClk;
			logic wantIsClk;
			logic switchOk;
			logic srcLevel;

			assign wantFn = pickFn(auxCode[g], ovrAllowed);
			assign curIsClk = (curFn_r[g] == FN_REF)
				|| (curFn_r[g] == FN_DIV2) || (curFn_r[g] == FN_DIV4);
			assign wantIsClk = (wantFn == FN_REF)
				|| (wantFn == FN_DIV2) || (wantFn == FN_DIV4);
			// Swap clocks only when every source is about to sit low,
			// so no runt pulse escapes; non-clock swaps are immediate
			assign switchOk = (!curIsClk && !wantIsClk)
				|| (refFall && refWrapNext); // see [R20]

			// Straps are live from reset, no write is needed
			always_ff @(posedge clk_sys or negedge nrst) begin // see [R9]
				if (!nrst) begin
					curFn_r[g] <= FN_OFF;
				end else if (clkEn) begin
					if (powerDownPin) begin
						curFn_r[g] <= FN_OFF; // see [R10]
					end else if (wantFn != curFn_r[g] && switchOk) begin
						curFn_r[g] <= wantFn;
					end
				end
			end

			always_comb begin
				case (curFn_r[g])
					FN_REF: srcLevel = refLevel_r;
					FN_DIV2: srcLevel = refDiv[0]; // see [R20]
					FN_DIV4: srcLevel = refDiv[1]; // see [R20]
					FN_OVR: srcLevel = overRangeIn[g];
					FN_OFF: srcLevel = 1'b0;
					default: srcLevel = 1'b0;
				endcase
			end

			// Power-down drops the pin at once, not at a clock boundary
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					auxOut_r[g] <= 1'b0;
				end else if (clkEn) begin
					auxOut_r[g] <= srcLevel & ~powerDownPin; // see [R10]
				end
			end
		end
	endgenerate

	assign auxOutC = auxOut_r[AUX_C];
	assign auxOutD = auxOut_r[AUX_D];
	assign auxCFunction = curFn_r[AUX_C];
	assign auxDFunction = curFn_r[AUX_D];

endmodule

// ### hw/ref_divider.sv
`timescale 1ns/1ns
module ref_divider
	import clock_output_select_pkg::*;
#(
	parameter int DIV_BITS = REF_DIV_BITS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clkEn,
	// Reference edge and run control
	input wire logic refRise,
	input wire logic run,
	// Divided copies, bit k is reference / 2^(k+1)
	output logic [DIV_BITS-1:0] divOut,
	output logic wrapNext
);

	logic [DIV_BITS-1:0] count_r;

	// =====================================================
	// Synchronous ripple-free counter
	// One counter for all ratios keeps the divided clocks in phase
	always_ff @(posedge clk_sys or negedge nrst) begin // see [R20]
		if (!nrst) begin
			count_r <= '0;
		end else if (clkEn) begin
			if (!run) begin
				count_r <= '0;
			end else if (refRise) begin
				count_r <= count_r + 1'b1;
			end
		end
	end

	assign divOut = count_r;
	assign wrapNext = (count_r == '0);

endmodule

// ### include/clock_output_select_pkg.sv
// How it works
// [R1] Repeat output copies the selected reference input
// [R2] Repeat output on with PLL, off when disabled
// [R3] Repeat output needs PLL pin high, no power-down
// [R4] Power-down pin always silences the repeat output
// [R5] Trigger output: retimed time mark or serializer clock
// [R6] Trigger output stays off until host enables it
// [R7] Enable, mode and divider share one control register
// [R8] Serializer source divided by the receiver divider value
// [R9] Aux outputs run from straps without any writes
// [R10] Power-down pin silences both aux outputs
// [R11] Override enable hands aux selection to mode fields
// [R12] Straps divide aux C; aux D only on/off
// [R13] Clock function beats over-range on the same output
// [R14] Aux D clock needs aux C clock enabled
// [R15] Strap codes: off/over-range, ref, ref/2, ref/4 for C
// [R16] Override codes 0..3 select aux C function
// [R17] Nonzero straps give aux D the undivided reference
// [R18] Override codes 0..3 select aux D function
// [R19] Time mark forwarded only when enabled, mode 3
// [R20] Reference dividers are counters, switching glitch-free
package clock_output_select_pkg;

	// =====================================================
	// Trigger output control register layout
	localparam int TRIG_EN_BIT = 0;
	localparam int TRIG_MODE_LSB = 1;
	localparam int TRIG_MODE_W = 2;
	localparam int TRIG_DIV_LSB = 3;
	localparam int TRIG_DIV_W = 4;
	localparam int TRIG_CTRL_W = 7;
	localparam logic [TRIG_CTRL_W-1:0] TRIG_CTRL_RESET = 7'h00;
	localparam logic [TRIG_MODE_W-1:0] TRIG_MODE_TIMESTAMP = 2'h3;

	// =====================================================
	// Aux output selection codes, straps and mode fields alike
	localparam logic [1:0] AUX_CODE_OFF = 2'h0;
	localparam logic [1:0] AUX_CODE_REF = 2'h1;
	localparam logic [1:0] AUX_CODE_DIV2 = 2'h2;
	localparam logic [1:0] AUX_CODE_DIV4 = 2'h3;

	// =====================================================
	// Reference divider, aux output count and indices, aux function codes
	localparam int REF_DIV_BITS = 2;
	localparam int AUX_COUNT = 2;
	localparam int AUX_C = 0;
	localparam int AUX_D = 1;

	typedef enum logic [4:0] {
		FN_OFF = 5'h01,
		FN_OVR = 5'h02,
		FN_REF = 5'h04,
		FN_DIV2 = 5'h08,
		FN_DIV4 = 5'h10
	} aux_fn_t;

endpackage
